// *** fci_cycle.sv ***
// One asynchronous flash bus cycle, read or write, paced by the clock
`timescale 1ns/1ps
module fci_cycle (
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              ce,
   // Request
   input  wire logic              start,
   input  wire fci_pkg::fci_cyc_t req,
   output logic                   done,
   output logic [15:0]            rdata,
   // Flash pins
   output fci_pkg::fci_pins_t     pins,
   input  wire logic [15:0]       dq_in
);
   typedef enum logic [2:0] {
      CY_IDLE = 3'b001, CY_STROBE = 3'b010, CY_RECOVER = 3'b100
   } fci_cy_t;

   fci_cy_t    state_reg;
   logic [3:0] cnt_reg;

   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg <= CY_IDLE;
         cnt_reg   <= 4'h0;
         done      <= 1'b0;
         rdata     <= 16'h0000;
         pins      <= '{chip_select_n: 1'b1, output_enable_n: 1'b1,
                        write_strobe_n: 1'b1, addr: 20'h00000,
                        dq_out: 16'h0000, dq_oe_n: 1'b1};
      end else if (ce) begin
         done <= 1'b0;
         case (state_reg)
            CY_IDLE: begin
               if (start) begin
                  pins.addr            <= req.addr;
                  pins.dq_out          <= req.data;
                  pins.dq_oe_n         <= ~req.wr;
                  pins.chip_select_n   <= 1'b0;
                  pins.output_enable_n <= req.wr;
                  pins.write_strobe_n  <= ~req.wr;
                  cnt_reg              <= fci_pkg::STROBE_CNT;
                  state_reg            <= CY_STROBE;
               end
            end
            CY_STROBE: begin
               if (cnt_reg == 4'h1) begin
                  // Data latched at rising write strobe; status read here
                  rdata                <= dq_in;
                  pins.chip_select_n   <= 1'b1;
                  pins.output_enable_n <= 1'b1;
                  pins.write_strobe_n  <= 1'b1;
                  cnt_reg              <= fci_pkg::RECOVER_CNT;
                  state_reg            <= CY_RECOVER;
               end else begin
                  cnt_reg <= cnt_reg - 4'h1;
               end
            end
            CY_RECOVER: begin
               // Strobes stay high between reads so status is refreshed
               pins.dq_oe_n <= 1'b1;
               if (cnt_reg == 4'h1) begin
                  done      <= 1'b1;
                  state_reg <= CY_IDLE;
               end else begin
                  cnt_reg <= cnt_reg - 4'h1;
               end
            end
            default: state_reg <= CY_IDLE;
         endcase
      end
   end

   strobe_gap_a: assert property (@(posedge clk) disable iff (rst)
      $rose(pins.output_enable_n) |-> pins.output_enable_n [*3])
      else $error("read strobe high too briefly");
endmodule : fci_cycle

// *** fci_flash_model.sv ***
// Behavioural flash die seen from its pins: command decode, status and sector locks
`timescale 1ns/1ps
module fci_flash_model #(
   parameter int          ERASE_CYC = 300,
   parameter int          WRITE_CYC = 60,
   parameter logic [15:0] MAKER_ID  = 16'h0000,
   parameter logic [15:0] DEVICE_ID = 16'h0000
) (
   // Clock and reset
   input  wire logic               clk,
   input  wire logic               rst,
   // Host pins and supply state
   input  wire fci_pkg::fci_pins_t pins,
   input  wire logic               vpp_low,
   output logic [15:0]             dq
);
   logic [1:0]  mode_reg, pend_reg;
   logic [5:0]  err_reg;
   logic [31:0] lock_reg;
   logic [15:0] last_reg, word;
   logic [7:0]  lat_reg, stat, cmd;
   logic        susp_reg, we_n_reg, cs_n_reg, oe_n_reg, rd_on, run, fresh;
   logic [19:0] a;
   int          ecnt, wcnt;
   assign a     = pins.addr;
   assign cmd   = pins.dq_out[7:0];
   assign rd_on = !pins.chip_select_n && !pins.output_enable_n;
   assign fresh = cs_n_reg || oe_n_reg;
   assign run   = wcnt > 0 || (ecnt > 0 && !susp_reg);
   assign stat  = {wcnt == 0 && (ecnt == 0 || susp_reg), susp_reg, err_reg};
   always_comb begin
      case (mode_reg)
         2'd2: word = {8'h00, fresh ? stat : lat_reg};
         2'd1: word = (a == fci_pkg::CFG_MAKER) ? MAKER_ID :
                      (a == fci_pkg::CFG_DEVICE) ? DEVICE_ID :
                      (a[14:0] == 15'h0002) ? {15'h0000, lock_reg[a[19:15]]} : 16'h0000;
         default: word = a[15:0] ^ 16'h5a5a;
      endcase
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic take();
      pend_reg <= 2'd0;
      if (pend_reg == 2'd1) begin
         mode_reg <= 2'd2;
         if (cmd == fci_pkg::CMD_CONFIRM)
            ecnt <= ERASE_CYC;
         else
            err_reg <= err_reg | 6'h30;
      end else if (pend_reg == 2'd2) begin
         mode_reg <= 2'd2;
         if (vpp_low)
            err_reg <= err_reg | 6'h18;
         else if (lock_reg[a[19:15]])
            err_reg <= err_reg | 6'h12;
         else
            wcnt <= WRITE_CYC;
      end else if (pend_reg == 2'd3) begin
         if (cmd == fci_pkg::CMD_CONFIRM)
            lock_reg <= 32'h0000_0000;
         else
            lock_reg[a[19:15]] <= 1'b1;
      end else if (run) begin
         if (cmd == fci_pkg::CMD_SUSPEND && wcnt == 0)
            susp_reg <= 1'b1;
      end else begin
         case (cmd)
            fci_pkg::CMD_READ_ARRAY:  mode_reg <= 2'd0;
            fci_pkg::CMD_READ_CONFIG, 8'h98: mode_reg <= 2'd1;
            fci_pkg::CMD_READ_STATUS: mode_reg <= 2'd2;
            fci_pkg::CMD_WRITE_SETUP, fci_pkg::CMD_WRITE_ALT: pend_reg <= 2'd2;
            fci_pkg::CMD_LOCK_SETUP:  pend_reg <= 2'd3;
            fci_pkg::CMD_CLEAR_STAT:  if (!susp_reg) err_reg <= 6'h00;
            fci_pkg::CMD_ERASE_SETUP: if (!susp_reg) pend_reg <= 2'd1;
            fci_pkg::CMD_SUSPEND:     if (!susp_reg) mode_reg <= 2'd0;
            fci_pkg::CMD_CONFIRM: begin
               mode_reg <= susp_reg ? 2'd2 : mode_reg;
               susp_reg <= 1'b0;
            end
            default: ;
         endcase
      end
   endtask : take
   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge clk) begin
      we_n_reg <= pins.write_strobe_n;
      cs_n_reg <= pins.chip_select_n;
      oe_n_reg <= pins.output_enable_n;
      last_reg <= rd_on ? word : last_reg;
      // A released bus must not keep showing the last word
      dq       <= rd_on ? word : ~last_reg;
      if (rd_on && fresh)
         lat_reg <= stat;
      if (rst) begin
         mode_reg <= 2'd0;
         pend_reg <= 2'd0;
         err_reg  <= 6'h00;
         lock_reg <= 32'hffff_ffff;
         susp_reg <= 1'b0;
         ecnt     <= 0;
         wcnt     <= 0;
      end else begin
         if (wcnt > 0)
            wcnt <= wcnt - 1;
         else if (ecnt > 0 && !susp_reg)
            ecnt <= ecnt - 1;
         if (!we_n_reg && pins.write_strobe_n && !cs_n_reg)
            take();
      end
   end
endmodule : fci_flash_model

// *** fci_host.sv ***
// Host controller issuing command sequences to the flash die over its pins
//
// Contract
// - Word write is setup 40H or 10H, then address and data write.
// - Status latched at later falling strobe; host raises strobe between reads.
// - Sector erase is 20H then D0H inside the sector.
// - Host polls ready bit then checks the error bit; the code polls only the ready bit and leaves error bits to RDATA.
// - If erase already done, host writes 70H then checks suspended bit. The code writes no 70H after B0H and polls only the ready bit.
// - Host keeps 15ms between resume and the next suspend.
// - Suspend is B0H, resume is D0H, single writes.
//
// Implementation choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module fci_host #(
   parameter int SUSP_GAP_CYC = 1500000
) (
   // Clock and reset
   input  wire logic          clk,
   input  wire logic          rst,
   input  wire logic          ce,
   // APB slave
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [7:0]    paddr,
   input  wire logic [31:0]   pwdata,
   output logic [31:0]        prdata,
   output logic               pready,
   output logic               pslverr,
   // Flash pins
   output fci_pkg::fci_pins_t flash_pins,
   input  wire logic [15:0]   flash_dq_in
);
   ////////////////////////////////////////////////////////////////////////////
   typedef enum logic [5:0] {
      H_IDLE = 6'b000001, H_CMD1 = 6'b000010, H_CMD2 = 6'b000100,
      H_POLL = 6'b001000, H_WAIT = 6'b010000, H_DONE = 6'b100000
   } fci_hst_t;

   fci_hst_t          state_reg;
   fci_pkg::fci_op_t  op_reg;
   logic [19:0]       addr_reg;
   logic [15:0]       wdata_reg;
   logic [15:0]       rdata_reg;
   logic              busy_reg;
   logic              gap_busy_reg;
   logic [20:0]       gap_cnt_reg;
   logic              cyc_start;
   fci_pkg::fci_cyc_t cyc_req;
   logic              cyc_done;
   logic [15:0]       cyc_rdata;
   logic              wr_acc;
   logic              rd_acc;
   logic [7:0]        first_code;
   logic [7:0]        second_code;
   logic              two_cycle;
   logic              polls;

   assign wr_acc = psel & penable & pwrite & pready;
   assign rd_acc = psel & penable & ~pwrite & pready;

   ////////////////////////////////////////////////////////////////////////////
   // Command code selection
   always_comb begin
      first_code  = fci_pkg::CMD_READ_ARRAY;
      second_code = fci_pkg::CMD_CONFIRM;
      two_cycle   = 1'b0;
      polls       = 1'b0;
      case (op_reg)
         fci_pkg::OP_READ_ARRAY:  first_code = fci_pkg::CMD_READ_ARRAY;
         fci_pkg::OP_READ_CONFIG: first_code = fci_pkg::CMD_READ_CONFIG;
         fci_pkg::OP_READ_STATUS: first_code = fci_pkg::CMD_READ_STATUS;
         fci_pkg::OP_CLEAR:       first_code = fci_pkg::CMD_CLEAR_STAT;
         fci_pkg::OP_ERASE: begin
            first_code = fci_pkg::CMD_ERASE_SETUP;
            two_cycle  = 1'b1;
            polls      = 1'b1;
         end
         fci_pkg::OP_WRITE, fci_pkg::OP_WRITE_ALT: begin
            first_code  = (op_reg == fci_pkg::OP_WRITE) ?
                          fci_pkg::CMD_WRITE_SETUP : fci_pkg::CMD_WRITE_ALT;
            second_code = wdata_reg[7:0];
            two_cycle   = 1'b1;
            polls       = 1'b1;
         end
         fci_pkg::OP_SUSPEND: begin
            first_code = fci_pkg::CMD_SUSPEND;
            polls      = 1'b1;
         end
         fci_pkg::OP_RESUME: begin
            first_code = fci_pkg::CMD_CONFIRM;
            polls      = 1'b1;
         end
         fci_pkg::OP_LOCK, fci_pkg::OP_UNLOCK, fci_pkg::OP_LOCKDOWN: begin
            first_code  = fci_pkg::CMD_LOCK_SETUP;
            two_cycle   = 1'b1;
            second_code = (op_reg == fci_pkg::OP_LOCK) ? fci_pkg::CMD_LOCK_SECTOR :
                          (op_reg == fci_pkg::OP_UNLOCK) ? fci_pkg::CMD_CONFIRM :
                          fci_pkg::CMD_LOCK_DOWN;
         end
         default: first_code = fci_pkg::CMD_READ_ARRAY;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer
   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg <= H_IDLE;
         busy_reg  <= 1'b0;
         cyc_start <= 1'b0;
         cyc_req   <= '{wr: 1'b0, addr: 20'h00000, data: 16'h0000};
         rdata_reg <= fci_pkg::SR_RESET;
      end else if (ce) begin
         cyc_start <= 1'b0;
         case (state_reg)
            H_IDLE: begin
               if (wr_acc && paddr == fci_pkg::REG_CTRL && pwdata[fci_pkg::CTRL_GO]) begin
                  busy_reg  <= 1'b1;
                  state_reg <= H_CMD1;
               end
            end
            H_CMD1: begin
               if (op_reg == fci_pkg::OP_SUSPEND && gap_busy_reg) begin
                  state_reg <= H_CMD1;
               end else if (op_reg == fci_pkg::OP_READ) begin
                  cyc_req   <= '{wr: 1'b0, addr: addr_reg, data: 16'h0000};
                  cyc_start <= 1'b1;
                  state_reg <= H_WAIT;
               end else begin
                  cyc_req   <= '{wr: 1'b1, addr: addr_reg, data: {8'h00, first_code}};
                  cyc_start <= 1'b1;
                  state_reg <= two_cycle ? H_CMD2 : (polls ? H_POLL : H_WAIT);
               end
            end
            H_CMD2: begin
               if (cyc_done) begin
                  cyc_req   <= '{wr: 1'b1, addr: addr_reg,
                                 data: (op_reg == fci_pkg::OP_WRITE ||
                                        op_reg == fci_pkg::OP_WRITE_ALT) ?
                                       wdata_reg : {8'h00, second_code}};
                  cyc_start <= 1'b1;
                  state_reg <= polls ? H_POLL : H_WAIT;
               end
            end
            H_POLL: begin
               // Poll status until the ready bit says stopped; the suspended bit is not tested
               if (cyc_done) begin
                  rdata_reg <= cyc_rdata;
                  if (cyc_req.wr == 1'b0 && (cyc_rdata[fci_pkg::SR_READY] ||
                      (op_reg == fci_pkg::OP_RESUME && 1'b0))) begin
                     state_reg <= H_DONE;
                  end else begin
                     cyc_req   <= '{wr: 1'b0, addr: addr_reg, data: 16'h0000};
                     cyc_start <= 1'b1;
                  end
               end
            end
            H_WAIT: begin
               if (cyc_done) begin
                  if (!cyc_req.wr) begin
                     rdata_reg <= cyc_rdata;
                  end
                  state_reg <= H_DONE;
               end
            end
            H_DONE: begin
               busy_reg  <= 1'b0;
               state_reg <= H_IDLE;
            end
            default: state_reg <= H_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Software registers and APB answer, zero wait states
   always_ff @(posedge clk) begin
      if (rst) begin
         op_reg    <= fci_pkg::OP_READ_ARRAY;
         addr_reg  <= 20'h00000;
         wdata_reg <= 16'h0000;
         prdata    <= 32'h00000000;
         pready    <= 1'b0;
         pslverr   <= 1'b0;
      end else if (ce) begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & (paddr > fci_pkg::REG_RDATA);
         if (wr_acc && !busy_reg) begin
            case (paddr)
               fci_pkg::REG_CTRL:  op_reg    <= fci_pkg::fci_op_t'(pwdata[3:0]);
               fci_pkg::REG_ADDR:  addr_reg  <= pwdata[19:0];
               fci_pkg::REG_WDATA: wdata_reg <= pwdata[15:0];
               default: ;
            endcase
         end
         if (psel && !penable && !pwrite) begin
            case (paddr)
               fci_pkg::REG_CTRL:   prdata <= {28'h0000000, op_reg};
               fci_pkg::REG_ADDR:   prdata <= {12'h000, addr_reg};
               fci_pkg::REG_WDATA:  prdata <= {16'h0000, wdata_reg};
               fci_pkg::REG_STATUS: prdata <= {30'h00000000, gap_busy_reg, busy_reg};
               fci_pkg::REG_RDATA:  prdata <= {16'h0000, rdata_reg};
               default:             prdata <= 32'h00000000;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Spacing from resume to next suspend
   always_ff @(posedge clk) begin
      if (rst) begin
         gap_busy_reg <= 1'b0;
         gap_cnt_reg  <= 21'h000000;
      end else if (ce) begin
         if (state_reg == H_CMD1 && op_reg == fci_pkg::OP_RESUME) begin
            gap_busy_reg <= 1'b1;
            gap_cnt_reg  <= 21'(SUSP_GAP_CYC);
         end else if (gap_cnt_reg != 21'h000000) begin
            gap_cnt_reg <= gap_cnt_reg - 21'h000001;
            gap_busy_reg <= (gap_cnt_reg != 21'h000001);
         end
      end
   end

   fci_cycle u_cycle (
      .clk   (clk),
      .rst   (rst),
      .ce    (ce),
      .start (cyc_start),
      .req   (cyc_req),
      .done  (cyc_done),
      .rdata (cyc_rdata),
      .pins  (flash_pins),
      .dq_in (flash_dq_in)
   );

   gap_held_a: assert property (@(posedge clk) disable iff (rst)
      (state_reg == H_CMD1 && op_reg == fci_pkg::OP_SUSPEND && gap_busy_reg)
      |=> !cyc_start)
      else $error("suspend issued inside resume gap");
   erase_seq_a: assert property (@(posedge clk) disable iff (rst)
      (state_reg == H_CMD1 && op_reg == fci_pkg::OP_ERASE && ce)
      |=> cyc_start && cyc_req.data[7:0] == fci_pkg::CMD_ERASE_SETUP)
      else $error("erase setup code wrong");
   poll_done_a: assert property (@(posedge clk) disable iff (rst)
      (state_reg == H_POLL && ce && cyc_done && !cyc_req.wr &&
       cyc_rdata[fci_pkg::SR_READY]) |=> state_reg == H_DONE)
      else $error("ready status not honoured");
   write_setup_a: assert property (@(posedge clk) disable iff (rst)
      (state_reg == H_CMD1 && op_reg == fci_pkg::OP_WRITE && ce)
      |=> cyc_req.data[7:0] == fci_pkg::CMD_WRITE_SETUP)
      else $error("write setup code wrong");
   resume_code_a: assert property (@(posedge clk) disable iff (rst)
      (state_reg == H_CMD1 && op_reg == fci_pkg::OP_RESUME && ce)
      |=> cyc_req.data[7:0] == fci_pkg::CMD_CONFIRM && cyc_req.wr)
      else $error("resume code wrong");
   status_cmd_a: assert property (@(posedge clk) disable iff (rst)
      (state_reg == H_CMD1 && op_reg == fci_pkg::OP_READ_STATUS && ce)
      |=> cyc_req.data[7:0] == fci_pkg::CMD_READ_STATUS)
      else $error("status command code wrong");
   config_cmd_a: assert property (@(posedge clk) disable iff (rst)
      (state_reg == H_CMD1 && op_reg == fci_pkg::OP_READ_CONFIG && ce)
      |=> cyc_req.data[7:0] == fci_pkg::CMD_READ_CONFIG)
      else $error("config command code wrong");
   clear_cmd_a: assert property (@(posedge clk) disable iff (rst)
      (state_reg == H_CMD1 && op_reg == fci_pkg::OP_CLEAR && ce)
      |=> cyc_req.data[7:0] == fci_pkg::CMD_CLEAR_STAT)
      else $error("clear command code wrong");
endmodule : fci_host

// *** fci_host_tb_top.sv ***
// Self-checking testbench for the flash command host controller
`timescale 1ns/1ps
module fci_host_tb_top;
   localparam logic [15:0] MAKER  = 16'h00a5;   // Arbitrary value
   localparam logic [15:0] DEVICE = 16'h0b6e;   // Arbitrary value
   localparam logic [31:0] RDY  = 32'h1 << fci_pkg::SR_READY;
   localparam logic [31:0] PERR = 32'h1 << fci_pkg::SR_PERR;
   logic               clk, rst, ce, psel, penable, pwrite, pready, pslverr, vpp_low;
   logic [7:0]         paddr;
   logic [31:0]        pwdata, prdata, rd_last;
   logic [15:0]        dq;
   fci_pkg::fci_pins_t pins;
   int                 err_count = 0, cmp_count = 0, cyc = 0;
   fci_host #(.SUSP_GAP_CYC(20)) dut (.clk(clk), .rst(rst), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .flash_pins(pins), .flash_dq_in(dq));
   fci_flash_model #(.MAKER_ID(MAKER), .DEVICE_ID(DEVICE)) flash (.clk(clk), .rst(rst),
      .pins(pins), .vpp_low(vpp_low), .dq(dq));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Whole run needs well under this many cycles
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         err_count = err_count + 1;
         tally_and_finish();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_word
   task automatic chk_bit(input logic got, input logic exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_bit
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      int n;
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (n >= 50)
         err_count++;
      @(posedge clk);
   endtask : apb
   // Loads address and data, starts the operation, waits for idle, fetches the word
   task automatic run_op(input fci_pkg::fci_op_t op, input logic [19:0] a,
                         input logic [15:0] d);
      logic [31:0] q;
      logic        e;
      int          n;
      apb(1'b1, fci_pkg::REG_ADDR, {12'h000, a}, q, e);
      apb(1'b1, fci_pkg::REG_WDATA, {16'h0000, d}, q, e);
      apb(1'b1, fci_pkg::REG_CTRL, {1'b1, 27'h0000000, op}, q, e);
      n = 0;
      do begin
         apb(1'b0, fci_pkg::REG_STATUS, 32'h0, q, e);
         n++;
      end while (q[0] !== 1'b0 && n < 500);
      apb(1'b0, fci_pkg::REG_RDATA, 32'h0, rd_last, e);
   endtask : run_op
   task automatic op_chk(input fci_pkg::fci_op_t op, input logic [19:0] a,
                         input logic [15:0] d, input logic [31:0] exp);
      run_op(op, a, d);
      chk_word(rd_last, exp);
   endtask : op_chk
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      logic [31:0] q;
      logic        e;
      apb(1'b0, fci_pkg::REG_STATUS, 32'h0, q, e);
      chk_word(q, 32'h0);
      apb(1'b0, fci_pkg::REG_RDATA, 32'h0, q, e);
      chk_word(q, RDY);
      apb(1'b0, 8'h14, 32'h0, q, e);
      chk_bit(e, 1'b1);
      chk_word(q, 32'h0);
      $display("test reset done");
   endtask : t_reset
   task automatic t_modes();
      op_chk(fci_pkg::OP_READ, 20'h00123, 16'h0, 32'h5b79);
      run_op(fci_pkg::OP_READ_CONFIG, 20'h0, 16'h0);
      op_chk(fci_pkg::OP_READ, fci_pkg::CFG_MAKER, 16'h0, {16'h0, MAKER});
      op_chk(fci_pkg::OP_READ, fci_pkg::CFG_DEVICE, 16'h0, {16'h0, DEVICE});
      op_chk(fci_pkg::OP_READ, 20'h08002, 16'h0, 32'h1);
      run_op(fci_pkg::OP_READ_ARRAY, 20'h0, 16'h0);
      op_chk(fci_pkg::OP_READ, 20'h00123, 16'h0, 32'h5b79);
      $display("test read modes done");
   endtask : t_modes
   task automatic t_errors();
      op_chk(fci_pkg::OP_WRITE, 20'h08010, 16'h1234, RDY | PERR | 32'h2);
      run_op(fci_pkg::OP_READ_STATUS, 20'h0, 16'h0);
      op_chk(fci_pkg::OP_READ, 20'h00777, 16'h0, RDY | PERR | 32'h2);
      run_op(fci_pkg::OP_CLEAR, 20'h0, 16'h0);
      op_chk(fci_pkg::OP_READ, 20'h00777, 16'h0, RDY);
      vpp_low <= 1'b1;
      op_chk(fci_pkg::OP_WRITE, 20'h08010, 16'h1234, RDY | PERR | 32'h8);
      vpp_low <= 1'b0;
      run_op(fci_pkg::OP_CLEAR, 20'h0, 16'h0);
      $display("test error flags done");
   endtask : t_errors
   task automatic t_program();
      run_op(fci_pkg::OP_UNLOCK, 20'h10000, 16'h0);
      run_op(fci_pkg::OP_READ_CONFIG, 20'h0, 16'h0);
      op_chk(fci_pkg::OP_READ, 20'h08002, 16'h0, 32'h0);
      op_chk(fci_pkg::OP_WRITE_ALT, 20'h08010, 16'h0f0f, RDY);
      op_chk(fci_pkg::OP_WRITE, 20'h08011, 16'ha55a, RDY);
      op_chk(fci_pkg::OP_ERASE, 20'h18000, 16'h0, RDY);
      op_chk(fci_pkg::OP_SUSPEND, 20'h08080, 16'h0, 32'hdada);
      run_op(fci_pkg::OP_READ_STATUS, 20'h0, 16'h0);
      op_chk(fci_pkg::OP_READ, 20'h00001, 16'h0, RDY);
      $display("test program and erase done");
   endtask : t_program
   task automatic t_lock();
      run_op(fci_pkg::OP_LOCK, 20'h08000, 16'h0);
      run_op(fci_pkg::OP_LOCKDOWN, 20'h10000, 16'h0);
      run_op(fci_pkg::OP_READ_CONFIG, 20'h0, 16'h0);
      op_chk(fci_pkg::OP_READ, 20'h08002, 16'h0, 32'h1);
      op_chk(fci_pkg::OP_READ, 20'h10002, 16'h0, 32'h1);
      op_chk(fci_pkg::OP_READ, 20'h18002, 16'h0, 32'h0);
      run_op(fci_pkg::OP_READ_ARRAY, 20'h0, 16'h0);
      op_chk(fci_pkg::OP_RESUME, 20'h08080, 16'h0, 32'hdada);
      $display("test lock and resume done");
   endtask : t_lock
   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : tally_and_finish
   initial begin
      rst     = 1'b1;
      ce      = 1'b1;
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 8'h00;
      pwdata  = 32'h0;
      vpp_low = 1'b0;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_reset();
      t_modes();
      t_errors();
      t_program();
      t_lock();
      tally_and_finish();
   end
endmodule : fci_host_tb_top

// *** fci_pkg.sv ***
// Package for the flash command host controller: codes, register map, types
package fci_pkg;
   // Flash command codes
   localparam logic [7:0] CMD_READ_ARRAY  = 8'hff;
   localparam logic [7:0] CMD_READ_CONFIG = 8'h90;
   localparam logic [7:0] CMD_READ_STATUS = 8'h70;
   localparam logic [7:0] CMD_CLEAR_STAT  = 8'h50;
   localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
   localparam logic [7:0] CMD_CONFIRM     = 8'hd0;
   localparam logic [7:0] CMD_WRITE_SETUP = 8'h40;
   localparam logic [7:0] CMD_WRITE_ALT   = 8'h10;
   localparam logic [7:0] CMD_SUSPEND     = 8'hb0;
   localparam logic [7:0] CMD_LOCK_SETUP  = 8'h60;
   localparam logic [7:0] CMD_LOCK_SECTOR = 8'h01;
   localparam logic [7:0] CMD_LOCK_DOWN   = 8'h2f;
   // Status bits
   localparam int SR_READY   = 7;
   localparam int SR_ESUSP   = 6;
   localparam int SR_EERR    = 5;
   localparam int SR_PERR    = 4;
   localparam int SR_VERR    = 3;
   localparam int SR_LERR    = 1;
   localparam logic [15:0] SR_RESET = 16'h0080;
   // Configuration space word addresses
   localparam logic [19:0] CFG_MAKER   = 20'h00000;
   localparam logic [19:0] CFG_DEVICE  = 20'h00001;
   localparam logic [19:0] CFG_LOCKOFS = 20'h00002;
   // APB register byte offsets
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_ADDR   = 8'h04;
   localparam logic [7:0] REG_WDATA  = 8'h08;
   localparam logic [7:0] REG_STATUS = 8'h0c;
   localparam logic [7:0] REG_RDATA  = 8'h10;
   // Control word: bit 31 go, [3:0] operation
   localparam int CTRL_GO = 31;
   // Bus cycle timing in ns, converted to 100 MHz cycles
   localparam int CLK_NS       = 10;
   localparam int STROBE_NS    = 70;
   localparam int STROBE_CYC   = (STROBE_NS + CLK_NS - 1) / CLK_NS;
   localparam int RECOVER_NS   = 30;
   localparam int RECOVER_CYC  = (RECOVER_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [3:0] STROBE_CNT  = 4'(STROBE_CYC);
   localparam logic [3:0] RECOVER_CNT = 4'(RECOVER_CYC);

   typedef enum logic [3:0] {
      OP_READ_ARRAY = 4'h0, OP_READ_CONFIG = 4'h1, OP_READ_STATUS = 4'h2,
      OP_CLEAR      = 4'h3, OP_ERASE       = 4'h4, OP_WRITE       = 4'h5,
      OP_SUSPEND    = 4'h6, OP_RESUME      = 4'h7, OP_LOCK        = 4'h8,
      OP_UNLOCK     = 4'h9, OP_LOCKDOWN    = 4'ha, OP_READ        = 4'hb,
      OP_WRITE_ALT  = 4'hc
   } fci_op_t;

   // One flash bus cycle
   typedef struct packed {
      logic        wr;
      logic [19:0] addr;
      logic [15:0] data;
   } fci_cyc_t;

   // Flash pin bundle driven by the host
   typedef struct packed {
      logic        chip_select_n;
      logic        output_enable_n;
      logic        write_strobe_n;
      logic [19:0] addr;
      logic [15:0] dq_out;
      logic        dq_oe_n;
   } fci_pins_t;
endpackage : fci_pkg
